// *** hw/cpw_pkg.sv ***
package cpw_pkg;

  localparam int CNT_W = 16;
  localparam int PRE_W = 11;
  localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
  localparam logic [CNT_W-1:0] DUTY_RST = 16'h0000;
  localparam logic              FLOP_RST = 1'b0;

  // Source select codes
  localparam logic [2:0] SRC_DIV2048 = 3'h0;
  localparam logic [2:0] SRC_DIV128  = 3'h1;
  localparam logic [2:0] SRC_DIV32   = 3'h2;
  localparam logic [2:0] SRC_DIV8    = 3'h3;
  localparam logic [2:0] SRC_SLOW    = 3'h4;
  localparam logic [2:0] SRC_DIV2    = 3'h5;
  localparam logic [2:0] SRC_FAST    = 3'h6;
  localparam logic [2:0] SRC_EVENT   = 3'h7;

  // Prescaler tap positions (divide by 2^(tap+1))
  localparam int TAP_2048 = 10;
  localparam int TAP_128  = 6;
  localparam int TAP_32   = 4;
  localparam int TAP_8    = 2;
  localparam int TAP_2    = 0;
  localparam int SLOW_TAP_8 = 2;

  // Configuration carried as one group
  typedef struct packed {
    logic       run;
    logic [2:0] src;
    logic       src_option;
    logic       slow_mode;
    logic       flop_init;
  } cpw_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } cpw_state_t;

endpackage : cpw_pkg

// *** hw/cpw_pwm16.sv ***
`timescale 1ns/1ps
// Cascaded 16-bit PWM generator
module cpw_pwm16 #(
  parameter int CNT_W = cpw_pkg::CNT_W   // 9 to 16 bits; high byte is cut
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  // Configuration
  input  wire cpw_pkg::cpw_cfg_t cfg,
  input  wire logic             slow_tick,
  input  wire logic             event_in,
  // Duty write and read
  input  wire logic             duty_lo_wr,
  input  wire logic             duty_hi_wr,
  input  wire logic [7:0]       duty_wdata,
  output logic [CNT_W-1:0]      duty_rdata,
  // Outputs
  output logic                  period_irq,
  output logic                  pwm_n,
  output logic [CNT_W-1:0]      count
);

  ////////////////////////////////////////////////////////////////////
  logic                        tick;
  cpw_pkg::cpw_state_t         st_q, st_d;
  logic [CNT_W-1:0]            cnt_q, cnt_d;
  logic [CNT_W-1:0]            active_q, active_d;
  logic [CNT_W-1:0]            buf_q, buf_d;
  logic                        pend_q, pend_d;
  logic                        flop_q, flop_d;
  logic                        irq_q, irq_d;
  logic                        init_q, init_d;
  logic                        ovf, match;

  cpw_tick_sel u_tick (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .cfg       (cfg),
    .slow_tick (slow_tick),
    .event_in  (event_in),
    .tick      (tick)
  );

  ////////////////////////////////////////////////////////////////////
  // Run state machine
  always_comb
  begin
    case (st_q)
      cpw_pkg::ST_IDLE: st_d = cfg.run ? cpw_pkg::ST_RUN
                                       : cpw_pkg::ST_IDLE;
      cpw_pkg::ST_RUN:  st_d = cfg.run ? cpw_pkg::ST_RUN
                                       : cpw_pkg::ST_IDLE;
      default:          st_d = cpw_pkg::ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Counter, compare and output flop next values
  always_comb
  begin
    ovf      = tick && (&cnt_q);
    match    = tick && (cnt_q + CNT_W'(1) == active_q) && !ovf;
    cnt_d    = cnt_q;
    flop_d   = flop_q;
    irq_d    = 1'b0;
    active_d = active_q;
    buf_d    = buf_q;
    pend_d   = pend_q;
    init_d   = cfg.flop_init;
    // Two byte writes build one 16-bit duty word
    if (duty_lo_wr)
      buf_d[7:0] = duty_wdata;
    if (duty_hi_wr)
    begin
      buf_d[CNT_W-1:8] = duty_wdata[CNT_W-9:0];
      pend_d      = 1'b1;
    end
    if (st_q == cpw_pkg::ST_IDLE)
    begin
      // Stopped: counter cleared; only a new init level reloads the flop
      cnt_d  = CNT_W'(cpw_pkg::CNT_RST);
      if (!cfg.run && cfg.flop_init != init_q)
        flop_d = cfg.flop_init;
      if (pend_q)
      begin
        active_d = buf_q;
        pend_d   = duty_hi_wr;
      end
    end
    else if (tick)
    begin
      cnt_d = cnt_q + CNT_W'(1);
      if (match)
        flop_d = !flop_q;
      if (ovf)
      begin
        cnt_d  = CNT_W'(cpw_pkg::CNT_RST);
        flop_d = !flop_q;
        irq_d  = 1'b1;
        if (pend_q)
        begin
          active_d = buf_q;
          pend_d   = duty_hi_wr;
        end
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_q     <= cpw_pkg::ST_IDLE;
      cnt_q    <= CNT_W'(cpw_pkg::CNT_RST);
      active_q <= CNT_W'(cpw_pkg::DUTY_RST);
      buf_q    <= CNT_W'(cpw_pkg::DUTY_RST);
      pend_q   <= 1'b0;
      flop_q   <= cpw_pkg::FLOP_RST;
      irq_q    <= 1'b0;
      init_q   <= 1'b0;
    end
    else if (clk_en)
    begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      active_q <= active_d;
      buf_q    <= buf_d;
      pend_q   <= pend_d;
      flop_q   <= flop_d;
      irq_q    <= irq_d;
      init_q   <= init_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign pwm_n      = !flop_q;
  assign duty_rdata = active_q;
  assign period_irq = irq_q;
  assign count      = cnt_q;

  ////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_wrap;
    st_q == cpw_pkg::ST_RUN && clk_en && tick && (&cnt_q);
  endsequence

  property p_overflow_clear;
    @(posedge sys_clk) disable iff (sys_rst)
    s_wrap |=> cnt_q == '0 && irq_q;
  endproperty
  a_overflow_clear: assert property (p_overflow_clear)
    else $error("Overflow did not clear counter");

  property p_overflow_toggle;
    @(posedge sys_clk) disable iff (sys_rst)
    s_wrap |=> flop_q != $past(flop_q);
  endproperty
  a_overflow_toggle: assert property (p_overflow_toggle)
    else $error("Overflow did not toggle flop");

  property p_match_toggle;
    @(posedge sys_clk) disable iff (sys_rst)
    (st_q == cpw_pkg::ST_RUN && clk_en && match)
      |=> flop_q != $past(flop_q) && cnt_q == active_q;
  endproperty
  a_match_toggle: assert property (p_match_toggle)
    else $error("Match did not toggle flop");

  property p_pin_inverse;
    @(posedge sys_clk) disable iff (sys_rst)
    pwm_n == !flop_q;
  endproperty
  a_pin_inverse: assert property (p_pin_inverse)
    else $error("Pin not inverse of flop");

  property p_count_step;
    @(posedge sys_clk) disable iff (sys_rst)
    (st_q == cpw_pkg::ST_RUN && clk_en && tick && !(&cnt_q))
      |=> cnt_q == $past(cnt_q) + CNT_W'(1);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("Counter did not step");

  property p_run_hold_duty;
    @(posedge sys_clk) disable iff (sys_rst)
    (st_q == cpw_pkg::ST_RUN && !$rose(irq_q) && clk_en && !irq_d)
      |=> $stable(active_q);
  endproperty
  a_run_hold_duty: assert property (p_run_hold_duty)
    else $error("Duty changed outside period event");

  property p_idle_load;
    @(posedge sys_clk) disable iff (sys_rst)
    (st_q == cpw_pkg::ST_IDLE && clk_en && pend_q)
      |=> active_q == $past(buf_q);
  endproperty
  a_idle_load: assert property (p_idle_load)
    else $error("Stopped duty not loaded");

  property p_read_active;
    @(posedge sys_clk) disable iff (sys_rst)
    duty_hi_wr && st_q == cpw_pkg::ST_RUN && !irq_d
      |=> duty_rdata == $past(active_q);
  endproperty
  a_read_active: assert property (p_read_active)
    else $error("Read shows unloaded duty");

  property p_reset_flop;
    @(posedge sys_clk)
    sys_rst |=> flop_q == 1'b0;
  endproperty
  a_reset_flop: assert property (p_reset_flop)
    else $error("Reset did not clear flop");

  property p_stop_freeze;
    @(posedge sys_clk) disable iff (sys_rst)
    (st_q == cpw_pkg::ST_RUN && !cfg.run && clk_en)
      |=> flop_q == $past(flop_q);
  endproperty
  a_stop_freeze: assert property (p_stop_freeze)
    else $error("Stop changed output");

  property p_slow_gate;
    @(posedge sys_clk) disable iff (sys_rst)
    (cfg.slow_mode && cfg.src == cpw_pkg::SRC_FAST) |-> !tick;
  endproperty
  a_slow_gate: assert property (p_slow_gate)
    else $error("Fast source ticked in slow mode");

  // Wrap event seen from outside the sequences
  logic wrap_ev;
  assign wrap_ev = (st_q == cpw_pkg::ST_RUN) && tick && (&cnt_q);

  sequence s_match;
    st_q == cpw_pkg::ST_RUN && clk_en && match;
  endsequence

  sequence s_wrap_pend;
    s_wrap ##0 pend_q;
  endsequence

  property p_match_keep;
    @(posedge sys_clk) disable iff (sys_rst)
    s_match |=> !irq_q && cnt_q != '0;
  endproperty
  a_match_keep: assert property (p_match_keep)
    else $error("Match cleared counter");

  property p_irq_pulse;
    @(posedge sys_clk) disable iff (sys_rst)
    (irq_q && clk_en) |=> !irq_q;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("Interrupt longer than one cycle");

  property p_irq_only_wrap;
    @(posedge sys_clk) disable iff (sys_rst)
    (clk_en && !wrap_ev) |=> !irq_q;
  endproperty
  a_irq_only_wrap: assert property (p_irq_only_wrap)
    else $error("Interrupt without overflow");

  property p_idle_clear;
    @(posedge sys_clk) disable iff (sys_rst)
    (st_q == cpw_pkg::ST_IDLE && clk_en) |=> cnt_q == '0;
  endproperty
  a_idle_clear: assert property (p_idle_clear)
    else $error("Stopped counter not cleared");

  property p_wrap_load;
    @(posedge sys_clk) disable iff (sys_rst)
    s_wrap_pend |=> active_q == $past(buf_q);
  endproperty
  a_wrap_load: assert property (p_wrap_load)
    else $error("Pending duty not loaded at overflow");

  property p_idle_freeze;
    @(posedge sys_clk) disable iff (sys_rst)
    (st_q == cpw_pkg::ST_IDLE && clk_en &&
     (cfg.run || cfg.flop_init == init_q))
      |=> $stable(flop_q);
  endproperty
  a_idle_freeze: assert property (p_idle_freeze)
    else $error("Stopped output moved without init change");

  property p_init_load;
    @(posedge sys_clk) disable iff (sys_rst)
    (st_q == cpw_pkg::ST_IDLE && clk_en && !cfg.run &&
     cfg.flop_init != init_q)
      |=> flop_q == $past(cfg.flop_init);
  endproperty
  a_init_load: assert property (p_init_load)
    else $error("Init level not loaded");

  property p_hi_pend;
    @(posedge sys_clk) disable iff (sys_rst)
    (duty_hi_wr && clk_en) |=> pend_q;
  endproperty
  a_hi_pend: assert property (p_hi_pend)
    else $error("High byte write not pending");

  property p_lo_byte;
    @(posedge sys_clk) disable iff (sys_rst)
    (duty_lo_wr && clk_en) |=> buf_q[7:0] == $past(duty_wdata);
  endproperty
  a_lo_byte: assert property (p_lo_byte)
    else $error("Low byte not buffered");

endmodule : cpw_pwm16

// *** hw/cpw_tick_sel.sv ***
`timescale 1ns/1ps
// Prescaler and counter source selection
module cpw_tick_sel (
  // Clock and reset
  input  wire logic           sys_clk,
  input  wire logic           sys_rst,
  input  wire logic           clk_en,
  // Selection
  input  wire cpw_pkg::cpw_cfg_t cfg,
  input  wire logic           slow_tick,
  input  wire logic           event_in,
  // Result
  output logic                tick
);

  logic [cpw_pkg::PRE_W-1:0] pre_q, pre_d;
  logic [cpw_pkg::PRE_W-1:0] carry;
  logic [2:0]                spre_q, spre_d;
  logic                      ev_q, ev_d;
  logic                      ev_fall, slow8;

  // Per-bit rollover strobes of the fast prescaler
  genvar gi;
  generate
    for (gi = 0; gi < cpw_pkg::PRE_W; gi++)
    begin : g_carry
      assign carry[gi] = &pre_q[gi:0];
    end
  endgenerate

  // Next values of prescalers and event sampler
  always_comb
  begin
    pre_d   = cfg.run ? pre_q + 11'h001 : 11'h000;
    spre_d  = (cfg.run && slow_tick) ? spre_q + 3'h1 : spre_q;
    if (!cfg.run)
      spre_d = 3'h0;
    ev_d    = event_in;
    ev_fall = ev_q && !event_in;
    slow8   = slow_tick && (&spre_q[cpw_pkg::SLOW_TAP_8:0]);
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      pre_q  <= 11'h000;
      spre_q <= 3'h0;
      ev_q   <= 1'b0;
    end
    else if (clk_en)
    begin
      pre_q  <= pre_d;
      spre_q <= spre_d;
      ev_q   <= ev_d;
    end
  end

  // Source multiplexer; slow modes gate fast sources off
  always_comb
  begin
    case (cfg.src)
      cpw_pkg::SRC_DIV2048: tick = cfg.src_option ? slow8
                                   : carry[cpw_pkg::TAP_2048];
      cpw_pkg::SRC_DIV128:  tick = carry[cpw_pkg::TAP_128];
      cpw_pkg::SRC_DIV32:   tick = carry[cpw_pkg::TAP_32];
      cpw_pkg::SRC_DIV8:    tick = carry[cpw_pkg::TAP_8];
      cpw_pkg::SRC_SLOW:    tick = slow_tick;
      cpw_pkg::SRC_DIV2:    tick = carry[cpw_pkg::TAP_2];
      cpw_pkg::SRC_FAST:    tick = 1'b1;
      default:              tick = ev_fall;
    endcase
    if (cfg.slow_mode && cfg.src != cpw_pkg::SRC_SLOW)
      tick = (cfg.src == cpw_pkg::SRC_DIV2048) ? slow8 : 1'b0;
    if (!cfg.run)
      tick = 1'b0;
  end

endmodule : cpw_tick_sel

// *** test/cpw_load_model.sv ***
`timescale 1ns/1ps
// Far side: load on the inverted pin plus event and slow clock sources
module cpw_load_model (
  // Clock
  input  wire logic   sys_clk,
  // Load and sources
  input  wire logic   pwm_n,
  input  wire logic   ev_en,
  output logic        event_in,
  output logic        slow_tick,
  output logic [15:0] edges
);
  logic [3:0] div_q = 4'h0;
  logic       last_q = 1'b1;
  logic       latch_q = 1'b1;  // Port output latch written to one
  logic       pad;

  initial edges = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Free divider and edge count of the load input
  always @(posedge sys_clk)
  begin
    div_q <= div_q + 4'h1;
    last_q <= pad;
    if (pad !== last_q)
      edges <= edges + 16'h0001;
  end

  // One slow pulse every 16 cycles
  assign slow_tick = (div_q == 4'hf);
  // Pad level seen by the load passes through the port latch
  assign pad = pwm_n & latch_q;
  // Four-cycle phases, above the two-cycle minimum; idle high
  assign event_in = ev_en ? div_q[2] : 1'b1;
endmodule : cpw_load_model

// *** test/tb.sv ***
`timescale 1ns/1ps
// Self-checking bench of the cascaded PWM generator
module tb;
  localparam int W = 10;
  logic              sys_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              clk_en = 1'b1;
  cpw_pkg::cpw_cfg_t cfg = '0;
  logic              ev_en = 1'b0;
  logic              lo_wr = 1'b0;
  logic              hi_wr = 1'b0;
  logic [7:0]        wdata = 8'h00;
  logic [W-1:0]      rdata;
  logic [W-1:0]      count;
  logic              irq;
  logic              pwm_n;
  logic              slow_tick;
  logic              event_in;
  logic [15:0]       edges;
  int                n_fail = 0;
  int                checks = 0;

  always #12.5 sys_clk = ~sys_clk;

  cpw_pwm16 #(.CNT_W(W)) u_cpw_pwm16 (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .cfg(cfg),
    .slow_tick(slow_tick), .event_in(event_in), .duty_lo_wr(lo_wr),
    .duty_hi_wr(hi_wr), .duty_wdata(wdata), .duty_rdata(rdata),
    .period_irq(irq), .pwm_n(pwm_n), .count(count));

  cpw_load_model u_cpw_load_model (
    .sys_clk(sys_clk), .pwm_n(pwm_n), .ev_en(ev_en),
    .event_in(event_in), .slow_tick(slow_tick), .edges(edges));

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic finish_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  task automatic check(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Low byte first, then high byte
  task automatic write_duty(input logic [15:0] v);
    @(posedge sys_clk);
    lo_wr <= 1'b1;
    wdata <= v[7:0];
    @(posedge sys_clk);
    lo_wr <= 1'b0;
    hi_wr <= 1'b1;
    wdata <= v[15:8];
    @(posedge sys_clk);
    hi_wr <= 1'b0;
  endtask : write_duty

  // Bounded wait for the interrupt or for a pin change
  task automatic wait_on(input bit use_irq);
    logic p0;
    p0 = pwm_n;
    for (int i = 0; i < 2000; i++)
    begin
      @(posedge sys_clk);
      #1;
      if (use_irq ? (irq === 1'b1) : (pwm_n !== p0))
        return;
    end
    n_fail++;
    $display("wrong value wait expected event seen none");
    finish_test();
  endtask : wait_on

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    #1;
    check("pin", pwm_n, 1);
    check("count", count, 0);
    check("duty", rdata, 0);
    check("irq", irq, 0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_stopped();
    @(posedge sys_clk);
    cfg.flop_init <= 1'b1;
    write_duty(16'h0123);
    repeat (2) @(posedge sys_clk);
    #1;
    check("duty", rdata, 16'h0123);
    check("pin", pwm_n, 0);
    @(posedge sys_clk);
    cfg.flop_init <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    check("pin", pwm_n, 1);
    $display("test stopped done");
  endtask : t_stopped

  task automatic t_pwm();
    @(posedge sys_clk);
    cfg.src <= cpw_pkg::SRC_FAST;
    cfg.run <= 1'b1;
    wait_on(0);
    check("match", count, 16'h0123);
    @(posedge sys_clk);
    #1;
    check("keep", count, 16'h0124);
    write_duty(16'h0080);
    #1;
    check("duty", rdata, 16'h0123);
    wait_on(1);
    check("wrap", count, 0);
    check("pin", pwm_n, 1);
    check("duty", rdata, 16'h0080);
    @(posedge sys_clk);
    #1;
    check("irq", irq, 0);
    wait_on(0);
    check("match", count, 16'h0080);
    $display("test pwm done");
  endtask : t_pwm

  task automatic t_stop();
    logic [15:0] e0;
    @(posedge sys_clk);
    cfg.run <= 1'b0;
    #1;
    e0 = edges;
    repeat (20) @(posedge sys_clk);
    #1;
    check("frozen", pwm_n, 0);
    check("edges", edges, e0);
    @(posedge sys_clk);
    cfg.flop_init <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    check("pin", pwm_n, 0);
    @(posedge sys_clk);
    cfg.flop_init <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    check("pin", pwm_n, 1);
    $display("test stop done");
  endtask : t_stop

  task automatic t_rate();
    logic [2:0] src_l [11] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h4, 3'h0,
                               3'h0, 3'h7, 3'h1, 3'h4};
    int         exp_l [11] = '{4, 16, 64, 256, 256, 32, 0, 4, 64, 0, 32};
    logic [10:0] opt_v = 11'h080;
    logic [10:0] slw_v = 11'h600;
    int          c;
    bit          ok;
    for (int i = 0; i < 11; i++)
    begin
      @(posedge sys_clk);
      cfg.run <= 1'b0;
      cfg.src <= src_l[i];
      cfg.src_option <= opt_v[i];
      cfg.slow_mode <= slw_v[i];
      ev_en <= (src_l[i] == 3'h7);
      repeat (2) @(posedge sys_clk);
      cfg.run <= 1'b1;
      clk_en <= (i != 4);
      repeat (256) @(posedge sys_clk);
      clk_en <= 1'b1;
      repeat (256) @(posedge sys_clk);
      #1;
      c = int'(count);
      ok = (c + 2 >= exp_l[i]) && (c <= exp_l[i] + 2);
      check("rate", ok, 1);
    end
    $display("test rate done");
  endtask : t_rate

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_stopped();
    t_pwm();
    t_stop();
    t_rate();
    finish_test();
  end
endmodule : tb
